// >>> wdt_top.sv
// Purpose: two-stage watchdog timer with APB register access
// Assumes: single 40 MHz clock pclk, asynchronous active-low presetn
// Notes: debug halt input is a pin and is synchronised before use
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
`include "wdt_cfg.svh"
module wdt_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire wdt_pkg::wdt_apb_req_t apb_req,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   input wire logic cpu_halted,
   output logic wdt_irq,
   output logic wdt_sys_reset
);
   import wdt_pkg::*;

   // ==========================================================
   // debug halt synchroniser
   logic halt_s1_r, halt_s2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_s1_r <= 1'b0;
         halt_s2_r <= 1'b0;
      end else begin
         halt_s1_r <= cpu_halted;
         halt_s2_r <= halt_s1_r;
      end
   end

   // ==========================================================
   // apb decode
   logic wr_acc, rd_acc, rd_setup, mapped;
   always_comb begin
      wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
      rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
      rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
      unique case (apb_req.paddr)
         `WDT_OFF_LOAD, `WDT_OFF_VALUE, `WDT_OFF_CTRL, `WDT_OFF_ICLR,
         `WDT_OFF_RIS, `WDT_OFF_MIS, `WDT_OFF_LOCK, `WDT_OFF_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // ==========================================================
   // configuration and counter state
   logic [31:0] load_r, load_nxt, count_r, count_nxt;
   logic run_r, run_nxt, inten_r, inten_nxt, resen_r, resen_nxt;
   logic stall_r, stall_nxt, locked_r, locked_nxt, ris_r, ris_nxt;
   logic rst_out_r, rst_out_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic ready_r, ready_nxt, err_r, err_nxt;
   logic irq_r, irq_nxt;
   wdt_state_t state;

   logic cfg_wr, zero_hit, freeze, load_wr, ctrl_wr, clr_wr;
   always_comb begin
      cfg_wr = wr_acc && !locked_r;
      load_wr = cfg_wr && apb_req.paddr == `WDT_OFF_LOAD;
      ctrl_wr = cfg_wr && apb_req.paddr == `WDT_OFF_CTRL;
      clr_wr = wr_acc && apb_req.paddr == `WDT_OFF_ICLR;
      freeze = stall_r && halt_s2_r;
      zero_hit = run_r && !freeze && count_r == `WDT_ZERO32;
      state = !run_r ? WDT_IDLE : (ris_r ? WDT_ARMED : WDT_COUNT);
   end

   always_comb begin
      load_nxt = load_r;
      count_nxt = count_r;
      run_nxt = run_r;
      inten_nxt = inten_r;
      resen_nxt = resen_r;
      stall_nxt = stall_r;
      locked_nxt = locked_r;
      ris_nxt = ris_r;
      rst_out_nxt = 1'b0;
      if (load_wr) begin
         load_nxt = apb_req.pwdata;
      end
      if (ctrl_wr) begin
         // run and interrupt enables only ever set by software; reset enable and stall follow the written bits
         if (apb_req.pwdata[`WDT_CTRL_INTEN]) begin
            // one enable starts counter and interrupt
            run_nxt = 1'b1;
            inten_nxt = 1'b1;
         end
         resen_nxt = apb_req.pwdata[`WDT_CTRL_RESEN];
         stall_nxt = apb_req.pwdata[`WDT_CTRL_STALL];
      end
      // key unlocks, any other value locks
      if (wr_acc && apb_req.paddr == `WDT_OFF_LOCK) begin
         locked_nxt = apb_req.pwdata != `WDT_LOCK_KEY;
      end
      // clear drops the source; a same-cycle expiry below wins
      if (clr_wr) begin
         ris_nxt = 1'b0;
         count_nxt = load_r;
      end
      unique case (state)
         WDT_IDLE: begin
         end
         WDT_COUNT, WDT_ARMED: begin
            if (zero_hit) begin
               ris_nxt = 1'b1;
               count_nxt = load_r;
               if (ris_r && !clr_wr && resen_r) begin
                  rst_out_nxt = 1'b1;
               end
            end else if (!freeze && !clr_wr) begin
               count_nxt = count_r - 32'h00000001;
            end
         end
      endcase
      // running load write takes effect at once
      if (load_wr && run_r) begin
         count_nxt = apb_req.pwdata;
      end
      if (load_wr && apb_req.pwdata == `WDT_ZERO32 && run_r) begin
         ris_nxt = 1'b1;
      end
      if (!run_r && !run_nxt) begin
         count_nxt = load_nxt;
      end
      irq_nxt = ris_nxt && inten_nxt;
   end

   // ==========================================================
   // apb read path and response
   always_comb begin
      rdata_nxt = rdata_r;
      ready_nxt = apb_req.psel && !apb_req.penable;
      err_nxt = apb_req.psel && !apb_req.penable && !mapped;
      if (rd_setup) begin
         rdata_nxt = `WDT_ZERO32;
         unique case (apb_req.paddr)
            `WDT_OFF_LOAD: rdata_nxt = load_r;
            `WDT_OFF_VALUE: rdata_nxt = count_r;
            `WDT_OFF_CTRL: begin
               rdata_nxt[`WDT_CTRL_INTEN] = inten_r;
               rdata_nxt[`WDT_CTRL_RESEN] = resen_r;
               rdata_nxt[`WDT_CTRL_STALL] = stall_r;
            end
            `WDT_OFF_RIS: rdata_nxt[0] = ris_r;
            `WDT_OFF_MIS: rdata_nxt[0] = ris_r && inten_r;
            `WDT_OFF_LOCK: rdata_nxt[0] = locked_r;
            `WDT_OFF_STATUS: begin
               rdata_nxt[`WDT_ST_LOCKED] = locked_r;
               rdata_nxt[`WDT_ST_RUNNING] = run_r;
            end
            default: rdata_nxt = `WDT_ZERO32;
         endcase
      end
   end

   // ==========================================================
   // registers
   // counter, load, interrupt and lock state
   // reset clears lock; reset output registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_r <= `WDT_LOAD_RST;
         count_r <= `WDT_LOAD_RST;
         run_r <= 1'b0;
         inten_r <= 1'b0;
         resen_r <= 1'b0;
         stall_r <= 1'b0;
         locked_r <= 1'b0;
         ris_r <= 1'b0;
         rst_out_r <= 1'b0;
         irq_r <= 1'b0;
         rdata_r <= `WDT_ZERO32;
         ready_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         load_r <= load_nxt;
         count_r <= count_nxt;
         run_r <= run_nxt;
         inten_r <= inten_nxt;
         resen_r <= resen_nxt;
         stall_r <= stall_nxt;
         locked_r <= locked_nxt;
         ris_r <= ris_nxt;
         rst_out_r <= rst_out_nxt;
         irq_r <= irq_nxt;
         rdata_r <= rdata_nxt;
         ready_r <= ready_nxt;
         err_r <= err_nxt;
      end
   end

   always_comb begin
      pready = ready_r;
      pslverr = err_r;
      prdata = rdata_r;
      wdt_irq = irq_r;
      wdt_sys_reset = rst_out_r;
   end

   // ==========================================================
   // checks
   // locked load write
   a_lock_blocks_load: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && locked_r && apb_req.paddr == `WDT_OFF_LOAD) |=> $stable(load_r))
      else $error("load changed while locked");

   a_expiry_sets_int: assert property (@(posedge pclk) disable iff (!presetn)
      (zero_hit && !load_wr) |=> ris_r && count_r == $past(load_r))
      else $error("expiry did not raise interrupt and reload");

   a_second_resets: assert property (@(posedge pclk) disable iff (!presetn)
      (zero_hit && ris_r && resen_r && !clr_wr) |=> wdt_sys_reset)
      else $error("second timeout gave no reset");

   a_no_reset_dis: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(resen_r) |-> !wdt_sys_reset)
      else $error("reset asserted while disabled");

   a_enable_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      run_r |=> run_r && inten_r)
      else $error("enable dropped");

   a_enable_arms: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_wr && apb_req.pwdata[`WDT_CTRL_INTEN]) |=> run_r && inten_r)
      else $error("enable did not arm");

   a_load_running: assert property (@(posedge pclk) disable iff (!presetn)
      (load_wr && run_r) |=> count_r == $past(apb_req.pwdata))
      else $error("running load not applied");

   a_stall_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (freeze && !load_wr && !clr_wr) |=> $stable(count_r))
      else $error("counter moved while stalled");

   a_zero_load_int: assert property (@(posedge pclk) disable iff (!presetn)
      (load_wr && run_r && apb_req.pwdata == `WDT_ZERO32) |=> wdt_irq)
      else $error("zero load gave no interrupt");

   a_clear_drops: assert property (@(posedge pclk) disable iff (!presetn)
      (clr_wr && !zero_hit && !load_wr) |=> !ris_r)
      else $error("clear did not drop interrupt");

   a_count_down: assert property (@(posedge pclk) disable iff (!presetn)
      (run_r && !freeze && !clr_wr && !load_wr && count_r != `WDT_ZERO32)
      |=> count_r == $past(count_r) - 32'h00000001)
      else $error("counter did not step down");

   a_clear_reloads: assert property (@(posedge pclk) disable iff (!presetn)
      (clr_wr && !zero_hit && !load_wr) |=> count_r == $past(load_r))
      else $error("clear did not reload counter");

   a_reset_cause: assert property (@(posedge pclk) disable iff (!presetn)
      wdt_sys_reset |-> $past(zero_hit) && $past(ris_r) && $past(resen_r))
      else $error("reset output without second timeout");

   a_lock_blocks_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && locked_r && apb_req.paddr == `WDT_OFF_CTRL)
      |=> $stable(inten_r) && $stable(resen_r) && $stable(stall_r))
      else $error("control changed while locked");

   a_unlock_key: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && apb_req.paddr == `WDT_OFF_LOCK && apb_req.pwdata == `WDT_LOCK_KEY)
      |=> !locked_r)
      else $error("unlock key did not unlock");

   a_lock_other: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && apb_req.paddr == `WDT_OFF_LOCK && apb_req.pwdata != `WDT_LOCK_KEY)
      |=> locked_r)
      else $error("lock write did not lock");

   a_lock_reads: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_setup && apb_req.paddr == `WDT_OFF_LOCK)
      |=> prdata == {31'h00000000, $past(locked_r)})
      else $error("lock status read mismatch");

   a_reload_reads: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_setup && apb_req.paddr == `WDT_OFF_LOAD) |=> prdata == $past(load_r))
      else $error("load read-back mismatch");

   a_value_reads: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_setup && apb_req.paddr == `WDT_OFF_VALUE) |=> prdata == $past(count_r))
      else $error("counter value read mismatch");

   a_read_ready: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc |-> pready)
      else $error("read access not answered");

   a_raw_status: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_setup && apb_req.paddr == `WDT_OFF_RIS) |=> prdata[0] == $past(ris_r))
      else $error("raw status read mismatch");

   a_masked_status: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_setup && apb_req.paddr == `WDT_OFF_MIS)
      |=> prdata[0] == ($past(ris_r) && $past(inten_r)))
      else $error("masked status read mismatch");

   a_run_status: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_setup && apb_req.paddr == `WDT_OFF_STATUS)
      |=> prdata[`WDT_ST_RUNNING] == $past(run_r))
      else $error("running status read mismatch");
endmodule : wdt_top

// >>> wdt_cfg.svh
// Purpose: register offsets, field positions and reset values of the watchdog
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: included by the package and by the watchdog top
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_OFF_LOAD 12'h000
`define WDT_OFF_VALUE 12'h004
`define WDT_OFF_CTRL 12'h008
`define WDT_OFF_ICLR 12'h00C
`define WDT_OFF_RIS 12'h010
`define WDT_OFF_MIS 12'h014
`define WDT_OFF_LOCK 12'h018
`define WDT_OFF_STATUS 12'h01C
`define WDT_CTRL_INTEN 0
`define WDT_CTRL_RESEN 1
`define WDT_CTRL_STALL 2
`define WDT_ST_LOCKED 0
`define WDT_ST_RUNNING 1
`define WDT_LOCK_KEY 32'h1ACCE551
`define WDT_LOAD_RST 32'hFFFFFFFF
`define WDT_ZERO32 32'h00000000
`endif

// >>> wdt_pkg.sv
// Purpose: shared types of the watchdog
// Assumes: wdt_cfg.svh holds the register numbers; struct widths and state codes are literal here
// Notes: apb request travels as one packed struct
`include "wdt_cfg.svh"
package wdt_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } wdt_apb_req_t;
   typedef enum logic [1:0] {
      WDT_IDLE = 2'b00,
      WDT_COUNT = 2'b01,
      WDT_ARMED = 2'b11
   } wdt_state_t;
endpackage : wdt_pkg

// >>> two_stage_watchdog_timer_test.sv
// Purpose: self-checking bench of the two-stage watchdog over its apb port
// Assumes: slave answers within a few access cycles; load values kept small
// Notes: random load values come from a fixed seed, corner cases in between
`timescale 1ns/10ps
`include "wdt_cfg.svh"
module two_stage_watchdog_timer_test;
   import wdt_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   wdt_apb_req_t apb_req = '0;
   logic cpu_halted = 1'b0;
   logic pready, pslverr, wdt_irq, wdt_sys_reset;
   logic [31:0] prdata, rd, ld, ld2, v1;
   logic err;
   int n_mismatch = 0;
   int compares = 0;
   int n_rst = 0;
   int snap;

   wdt_top DUT (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .cpu_halted(cpu_halted), .wdt_irq(wdt_irq),
      .wdt_sys_reset(wdt_sys_reset));

   always #12.5 pclk = ~pclk;

   // counts reset pulses so a stray one shows up later
   always @(posedge pclk) begin
      if (wdt_sys_reset === 1'b1) n_rst <= n_rst + 1;
   end

   // ==========================================================
   // reporting
   task automatic finish_test();
      if (n_mismatch == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      compares++;
      if (((got >= lo) && (got <= hi)) !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : chk_rng

   // expected status word from lock and run state
   function automatic logic [31:0] status_word(input logic locked, input logic running);
      status_word = `WDT_ZERO32;
      status_word[`WDT_ST_LOCKED] = locked;
      status_word[`WDT_ST_RUNNING] = running;
   endfunction : status_word

   // ==========================================================
   // bus and waiting
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      apb_req <= '0;
      if (pready !== 1'b1) begin
         n_mismatch++;
         finish_test();
      end
   endtask : apb

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc

   // bounded wait; running out counts as a mismatch and ends the run
   task automatic wait_hi(ref logic s, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge pclk);
         if (s === 1'b1) break;
      end
      if (s !== 1'b1) begin
         n_mismatch++;
         finish_test();
      end
   endtask : wait_hi

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(83418));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`WDT_OFF_LOAD, 32'hFFFFFFFF);
      rdc(`WDT_OFF_STATUS, status_word(1'b0, 1'b0));
      rdc(`WDT_OFF_RIS, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk(err, 32'h1);
      repeat (3) begin
         ld = $urandom_range(60, 30);
         apb(1'b1, `WDT_OFF_LOAD, ld);
         rdc(`WDT_OFF_LOAD, ld);
      end
      rdc(`WDT_OFF_VALUE, ld);
      apb(1'b1, `WDT_OFF_CTRL, 32'h3);
      rdc(`WDT_OFF_STATUS, status_word(1'b0, 1'b1));
      wait_hi(wdt_irq, 80);
      rdc(`WDT_OFF_MIS, 32'h1);
      apb(1'b0, `WDT_OFF_VALUE, 32'h0);
      chk_rng(rd, ld - 10, ld);
      repeat (ld - 20) @(posedge pclk);
      apb(1'b1, `WDT_OFF_ICLR, 32'h0);
      apb(1'b0, `WDT_OFF_VALUE, 32'h0);
      chk_rng(rd, ld - 8, ld);
      rdc(`WDT_OFF_RIS, 32'h0);
      chk(wdt_irq, 32'h0);
      wait_hi(wdt_irq, 80);
      wait_hi(wdt_sys_reset, 80);
      chk(wdt_irq, 32'h1);
      apb(1'b1, `WDT_OFF_ICLR, 32'h0);
      ld2 = $urandom_range(200, 100);
      apb(1'b1, `WDT_OFF_LOAD, ld2);
      apb(1'b0, `WDT_OFF_VALUE, 32'h0);
      chk_rng(rd, ld2 - 8, ld2);
      apb(1'b1, `WDT_OFF_LOAD, 32'h0);
      wait_hi(wdt_irq, 6);
      apb(1'b1, `WDT_OFF_LOAD, ld2);
      apb(1'b1, `WDT_OFF_CTRL, 32'h0);
      apb(1'b1, `WDT_OFF_ICLR, 32'h0);
      rdc(`WDT_OFF_STATUS, status_word(1'b0, 1'b1));
      snap = n_rst;
      wait_hi(wdt_irq, ld2 + 20);
      repeat (ld2 + 20) @(posedge pclk);
      chk(n_rst, snap);
      apb(1'b1, `WDT_OFF_ICLR, 32'h0);
      apb(1'b1, `WDT_OFF_CTRL, 32'h4);
      cpu_halted <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, `WDT_OFF_VALUE, 32'h0);
      v1 = rd;
      repeat (10) @(posedge pclk);
      rdc(`WDT_OFF_VALUE, v1);
      cpu_halted <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, `WDT_OFF_VALUE, 32'h0);
      chk_rng(rd, v1 - 20, v1 - 1);
      apb(1'b1, `WDT_OFF_LOCK, $urandom_range(1000, 1));
      rdc(`WDT_OFF_STATUS, status_word(1'b1, 1'b1));
      rdc(`WDT_OFF_LOCK, 32'h1);
      apb(1'b1, `WDT_OFF_LOAD, 32'h5);
      rdc(`WDT_OFF_LOAD, ld2);
      apb(1'b1, `WDT_OFF_CTRL, 32'h0);
      rdc(`WDT_OFF_CTRL, (32'h1 << `WDT_CTRL_INTEN) | (32'h1 << `WDT_CTRL_STALL));
      apb(1'b1, `WDT_OFF_LOCK, `WDT_LOCK_KEY);
      rdc(`WDT_OFF_STATUS, status_word(1'b0, 1'b1));
      apb(1'b1, `WDT_OFF_LOAD, ld);
      rdc(`WDT_OFF_LOAD, ld);
      apb(1'b1, `WDT_OFF_LOCK, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`WDT_OFF_STATUS, status_word(1'b0, 1'b0));
      rdc(`WDT_OFF_LOAD, 32'hFFFFFFFF);
      finish_test();
   end
endmodule : two_stage_watchdog_timer_test
